/* File: core/iosb_pkg.sv */
`default_nettype none
package iosb_pkg;
  // io space geometry
  localparam int IO_DEPTH = 64;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int FLAG_BITS = 4;
  // window reachable by single-bit operations
  localparam logic [5:0] BIT_ADDR_LO = 6'h00;
  localparam logic [5:0] BIT_ADDR_HI = 6'h1F;
  // one bit per address, set where a register is implemented
  localparam logic [63:0] IMPL_ADDR_MAP = 64'h0F0F_0FFF_FFFF_FF3F;
  // status flag register, write-one-to-clear in its low bits
  localparam logic [5:0] FLAG_ADDR = 6'h08;
  localparam logic [7:0] FLAG_W1C_MASK = 8'h0F;
  localparam logic [7:0] FULL_MASK = 8'hFF;
  localparam logic [7:0] NO_MASK = 8'h00;
  localparam logic [7:0] BIT0_MASK = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [1:0] {
    IOSB_IO_BIT_SET_OP = 2'b00,
    IOSB_IO_BIT_CLEAR_OP = 2'b01,
    IOSB_SKIP_IF_IO_BIT_SET_OP = 2'b10,
    IOSB_SKIP_IF_IO_BIT_CLEAR_OP = 2'b11
  } iosb_op_t;
endpackage : iosb_pkg
`default_nettype wire

/* File: core/iosb_op_if.sv */
`default_nettype none
interface iosb_op_if
  import iosb_pkg::*;
  ();
  // request from the core side
  logic opValid;
  iosb_op_t opCode;
  logic [5:0] opAddr;
  logic [2:0] opBit;
  // decoded view
  logic inRange;
  logic [7:0] bitMask;
  logic isSet;
  logic isClr;
  logic isTest;

  modport core (output opValid, output opCode, output opAddr, output opBit,
    input inRange, input bitMask, input isSet, input isClr, input isTest);
  modport dec (input opValid, input opCode, input opAddr, input opBit,
    output inRange, output bitMask, output isSet, output isClr, output isTest);
endinterface : iosb_op_if
`default_nettype wire

/* File: core/iosb_bitop_dec.sv */
`default_nettype none
module iosb_bitop_dec
  import iosb_pkg::*;
(
  iosb_op_if.dec op // bit operation request and its decode
);
  // lower bound is address zero, so only the top needs checking
  assign op.inRange = (op.opAddr <= BIT_ADDR_HI);
  assign op.bitMask = 8'(BIT0_MASK << op.opBit);

  // operations outside the window raise none of isSet, isClr or isTest
  always_comb
  begin
    op.isSet = 1'b0;
    op.isClr = 1'b0;
    op.isTest = 1'b0;
    if (op.opValid && op.inRange)
    begin
      case (op.opCode)
        IOSB_IO_BIT_SET_OP: op.isSet = 1'b1;
        IOSB_IO_BIT_CLEAR_OP: op.isClr = 1'b1;
        IOSB_SKIP_IF_IO_BIT_SET_OP: op.isTest = 1'b1;
        IOSB_SKIP_IF_IO_BIT_CLEAR_OP: op.isTest = 1'b1;
        default: op.isTest = 1'b0;
      endcase
    end
  end
endmodule : iosb_bitop_dec
`default_nettype wire

/* File: core/iosb_io_space.sv */
// Functional notes
// - bit set and clear reach only io addresses 0x00 through 0x1F.
// - bit tests on that range report skip when selected bit matches the test.
// - some status flags clear on writing one; writing zero leaves them unchanged.
// - bit set or clear changes only the addressed bit, never rewrites others.
`default_nettype none
module iosb_io_space
  import iosb_pkg::*;
(
  input wire logic ref_clk, // core clock, 250 MHz
  input wire logic resetn, // async reset, active low
  input wire logic ioWrEn, // byte write strobe
  input wire logic [5:0] ioWrAddr, // byte write address
  input wire logic [7:0] ioWrData, // byte write data
  input wire logic ioRdEn, // byte read strobe
  input wire logic [5:0] ioRdAddr, // byte read address
  input wire logic opValid, // bit operation strobe
  input wire iosb_op_t opCode, // bit operation kind
  input wire logic [5:0] opAddr, // bit operation address
  input wire logic [2:0] opBit, // bit operation bit index
  input wire logic [FLAG_BITS-1:0] flagEvt, // peripheral flag set pulses
  output logic [7:0] ioRdData_r, // read data, one cycle after ioRdEn
  output logic skipReq_r, // skip next instruction
  output logic opDone_r, // bit operation finished
  output logic opRejected_r, // bit operation outside window
  output wire logic [IO_DEPTH-1:0][7:0] ioRegView // live register contents
);
  logic [7:0] regMem_r [IO_DEPTH];
  logic curBit;
  logic [7:0] curReg;

  iosb_op_if op ();

  // the request runs on the same clock, so no synchroniser
  assign op.opValid = opValid;
  assign op.opCode = opCode;
  assign op.opAddr = opAddr;
  assign op.opBit = opBit;

  iosb_bitop_dec u_dec (
    .op(op)
  );

  assign curReg = regMem_r[opAddr];
  assign curBit = |(curReg & op.bitMask);

  // one storage cell per io address
  for (genvar a = 0; a < IO_DEPTH; a++)
  begin : g_reg
    localparam logic [5:0] ADDR = 6'(a);
    localparam logic [7:0] W1C = (ADDR == FLAG_ADDR) ? FLAG_W1C_MASK : NO_MASK;
    localparam logic [7:0] IMPL = !IMPL_ADDR_MAP[a] ? NO_MASK :
      ((ADDR == FLAG_ADDR) ? FLAG_W1C_MASK : FULL_MASK);
    logic [7:0] regMem_nxt;
    logic [7:0] hwSet;

    assign hwSet = (ADDR == FLAG_ADDR) ? 8'(flagEvt) : NO_MASK;
    assign ioRegView[a] = regMem_r[a];

    // next value: byte write, else bit op, then hardware flag sets
    always_comb
    begin
      regMem_nxt = regMem_r[a];
      if (ioWrEn && ioWrAddr == ADDR)
      begin
        // plain bits take data, flags clear on one and hold on zero
        regMem_nxt = (ioWrData & IMPL & ~W1C) | (regMem_r[a] & W1C & ~ioWrData);
      end
      else if (op.isSet && opAddr == ADDR)
      begin
        // only the addressed bit moves; a one on a flag clears it
        regMem_nxt = (regMem_r[a] | (op.bitMask & IMPL & ~W1C)) & ~(op.bitMask & W1C);
      end
      else if (op.isClr && opAddr == ADDR)
      begin
        // a zero onto a flag does nothing, so mask flags out
        regMem_nxt = regMem_r[a] & ~(op.bitMask & ~W1C);
      end
      // set wins over a clear in the same cycle so no event is lost
      regMem_nxt = regMem_nxt | (hwSet & IMPL);
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
        regMem_r[a] <= REG_RESET;
      else
        regMem_r[a] <= regMem_nxt;
    end
  end

  // read path; reserved cells never hold ones, so they read zero
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ioRdData_r <= REG_RESET;
    else if (ioRdEn)
      ioRdData_r <= regMem_r[ioRdAddr];
  end

  // skip decision for the two test operations
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      skipReq_r <= 1'b0;
    else if (op.isTest)
      skipReq_r <= (curBit == (opCode == IOSB_SKIP_IF_IO_BIT_SET_OP));
    else
      skipReq_r <= 1'b0;
  end

  // completion and rejection pulses
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      opDone_r <= 1'b0;
      opRejected_r <= 1'b0;
    end
    else
    begin
      opDone_r <= opValid;
      opRejected_r <= opValid && !op.inRange;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  logic [7:0] otherBits;
  assign otherBits = curReg & ~op.bitMask;

  sequence s_modify_op;
    (op.isSet || op.isClr) && !ioWrEn && flagEvt == '0;
  endsequence

  sequence s_test_op;
    op.isTest;
  endsequence

  a_range_reject_op: assert property (
    opValid && opAddr > BIT_ADDR_HI |=> opRejected_r && !skipReq_r)
    else $error("out-of-window bit operation not rejected");

  a_out_range_keep: assert property (
    opValid && opAddr > BIT_ADDR_HI && !ioWrEn |=> regMem_r[$past(opAddr)] == $past(curReg))
    else $error("out-of-window bit operation changed a register");

  // expected skip taken from the addressed bit itself, not from the decode
  a_skip_test_result: assert property (
    s_test_op |=> skipReq_r == (($past(opCode) == IOSB_SKIP_IF_IO_BIT_SET_OP) ?
      $past(curReg[opBit]) : !$past(curReg[opBit])))
    else $error("skip decision wrong");

  a_flag_w1c_clear: assert property (
    ioWrEn && ioWrAddr == FLAG_ADDR && ioWrData[0] && !flagEvt[0] |=> !regMem_r[FLAG_ADDR][0])
    else $error("flag not cleared by writing one");

  a_flag_zero_hold: assert property (
    ioWrEn && ioWrAddr == FLAG_ADDR && !ioWrData[0] && regMem_r[FLAG_ADDR][0]
    |=> regMem_r[FLAG_ADDR][0])
    else $error("flag lost on writing zero");

  a_single_bit_only: assert property (
    s_modify_op |=> (regMem_r[$past(opAddr)] & ~$past(op.bitMask)) == $past(otherBits))
    else $error("bit operation touched other bits");

  a_rsvd_read_zero: assert property (
    ioRdEn && (!IMPL_ADDR_MAP[ioRdAddr] || ioRdAddr == FLAG_ADDR)
    |=> (ioRdData_r & ~(IMPL_ADDR_MAP[$past(ioRdAddr)] ? FLAG_W1C_MASK : NO_MASK)) == NO_MASK)
    else $error("reserved bits read nonzero");

  sequence s_set_plain;
    op.isSet && !ioWrEn && opAddr != FLAG_ADDR && IMPL_ADDR_MAP[opAddr];
  endsequence

  sequence s_clr_plain;
    op.isClr && !ioWrEn && opAddr != FLAG_ADDR;
  endsequence

  sequence s_flag_op;
    (op.isSet || op.isClr) && !ioWrEn && opAddr == FLAG_ADDR && flagEvt == '0;
  endsequence

  // plain registers: the named bit must really move
  a_set_bit_lands: assert property (
    s_set_plain |=> regMem_r[$past(opAddr)][$past(opBit)])
    else $error("bit set operation did not set its bit");

  a_clr_bit_lands: assert property (
    s_clr_plain |=> !regMem_r[$past(opAddr)][$past(opBit)])
    else $error("bit clear operation did not clear its bit");

  // flag register: a set op writes one and clears, a clear op writes zero and keeps
  a_flag_set_clears: assert property (
    s_flag_op ##0 op.isSet |=> !regMem_r[FLAG_ADDR][$past(opBit)])
    else $error("set operation did not clear the flag");

  a_flag_clr_keeps: assert property (
    s_flag_op ##0 op.isClr |=> regMem_r[FLAG_ADDR] == $past(regMem_r[FLAG_ADDR]))
    else $error("clear operation changed the flag register");

  // a hardware event on flag bit 0 is never lost, even against a clearing write
  a_event_wins: assert property (
    flagEvt[0] |=> regMem_r[FLAG_ADDR][0])
    else $error("flag event lost");

  a_rsvd_op_none: assert property (
    (op.isSet || op.isClr) && !IMPL_ADDR_MAP[opAddr] |=> regMem_r[$past(opAddr)] == NO_MASK)
    else $error("bit operation changed a reserved address");

  a_skip_idle_low: assert property (
    !op.isTest |=> !skipReq_r)
    else $error("skip raised without a test operation");

  a_done_follows: assert property (
    opDone_r == $past(opValid))
    else $error("completion pulse does not follow the request");

  a_read_hold: assert property (
    !ioRdEn |=> $stable(ioRdData_r))
    else $error("read data changed without a read");
endmodule : iosb_io_space
`default_nettype wire

/* File: verification/iosb_core_model.sv */
`default_nettype none
module iosb_core_model
  import iosb_pkg::*;
(
  input wire logic ref_clk, // core clock
  output logic opValid, // bit op strobe
  output var iosb_op_t opCode, // bit op kind
  output logic [5:0] opAddr, // bit op address
  output logic [2:0] opBit // bit op index
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    opValid = 1'b0;
    opCode = IOSB_IO_BIT_SET_OP;
    opAddr = 6'h00;
    opBit = 3'h0;
  end
  // one op per call, strobe up for exactly one edge
  task automatic issue(input iosb_op_t c, input logic [5:0] a, input logic [2:0] b);
    @(negedge ref_clk);
    opValid = 1'b1;
    opCode = c;
    opAddr = a;
    opBit = b;
    @(negedge ref_clk);
    opValid = 1'b0;
    // released address and bit lines flip so a stale value never looks valid
    opAddr = ~a;
    opBit = ~b;
  endtask : issue
endmodule : iosb_core_model
`default_nettype wire

/* File: verification/io_space_bit_access_tb_top.sv */
`default_nettype none
module io_space_bit_access_tb_top
  import iosb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic ioWrEn = 1'b0;
  logic [5:0] ioWrAddr = 6'h00;
  logic [7:0] ioWrData = 8'h00;
  logic ioRdEn = 1'b0;
  logic [5:0] ioRdAddr = 6'h00;
  logic [3:0] flagEvt = 4'h0;
  logic opValid, skipReq_r, opDone_r, opRejected_r, rdSeen = 1'b0, opSeen = 1'b0;
  iosb_op_t opCode;
  logic [5:0] opAddr;
  logic [2:0] opBit;
  logic [7:0] ioRdData_r, seedVal = 8'h0E;
  logic [7:0] expMem [64] = '{default: 8'h00};
  logic [63:0][7:0] regView;
  logic [7:0] rq [$];
  logic [7:0] oq [$];
  int num_errors = 0;
  int comparisons = 0;
  always #2 ref_clk = ~ref_clk;
  iosb_core_model core (.ref_clk(ref_clk), .opValid(opValid), .opCode(opCode),
    .opAddr(opAddr), .opBit(opBit));
  iosb_io_space dut (.ref_clk(ref_clk), .resetn(resetn), .ioWrEn(ioWrEn),
    .ioWrAddr(ioWrAddr), .ioWrData(ioWrData), .ioRdEn(ioRdEn), .ioRdAddr(ioRdAddr),
    .opValid(opValid), .opCode(opCode), .opAddr(opAddr), .opBit(opBit),
    .flagEvt(flagEvt), .ioRdData_r(ioRdData_r), .skipReq_r(skipReq_r),
    .opDone_r(opDone_r), .opRejected_r(opRejected_r), .ioRegView(regView));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // byte write; flag bits clear on one, keep on zero
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {ioWrEn, ioWrAddr, ioWrData} = {1'b1, a, d};
    if (a == FLAG_ADDR)
      expMem[a] = expMem[a] & ~(d & FLAG_W1C_MASK);
    else if (IMPL_ADDR_MAP[a])
      expMem[a] = d;
    @(negedge ref_clk);
    ioWrEn = 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(negedge ref_clk);
    {ioRdEn, ioRdAddr} = {1'b1, a};
    rq.push_back(expMem[a]);
    @(negedge ref_clk);
    ioRdEn = 1'b0;
  endtask : rd
  task automatic evt(input logic [3:0] v);
    @(negedge ref_clk);
    flagEvt = v;
    expMem[FLAG_ADDR] = expMem[FLAG_ADDR] | {4'h0, v};
    @(negedge ref_clk);
    flagEvt = 4'h0;
  endtask : evt
  // expected effect of one bit op, then hand it to the core model
  task automatic op(input iosb_op_t c, input logic [5:0] a, input logic [2:0] b);
    logic hit;
    logic inWin;
    logic skip;
    hit = expMem[a][b];
    inWin = (a <= BIT_ADDR_HI);
    if (inWin && IMPL_ADDR_MAP[a] && c == IOSB_IO_BIT_SET_OP)
      expMem[a][b] = (a != FLAG_ADDR);
    if (inWin && a != FLAG_ADDR && c == IOSB_IO_BIT_CLEAR_OP)
      expMem[a][b] = 1'b0;
    skip = inWin && ((c == IOSB_SKIP_IF_IO_BIT_SET_OP && hit) ||
      (c == IOSB_SKIP_IF_IO_BIT_CLEAR_OP && !hit));
    oq.push_back({5'h00, skip, !inWin, 1'b1});
    core.issue(c, a, b);
  endtask : op
  // outputs sampled mid-cycle, oldest note compared
  always @(posedge ref_clk)
  begin
    rdSeen <= ioRdEn;
    opSeen <= opValid;
  end
  always @(negedge ref_clk)
  begin
    if (rdSeen)
      check(ioRdData_r, rq.pop_front());
    if (opSeen)
      check({5'h00, skipReq_r, opRejected_r, opDone_r}, oq.pop_front());
  end
  // about 2000 cycles expected; this is a generous ceiling
  initial
  begin
    #100000;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    // everything reads zero straight out of reset
    check(ioRdData_r, 8'h00);
    check({5'h00, skipReq_r, opRejected_r, opDone_r}, 8'h00);
    // reserved addresses are only read, never written
    for (int a = 0; a < IO_DEPTH; a++)
    begin
      seedVal = lfsr(seedVal);
      if (IMPL_ADDR_MAP[a])
        wr(a[5:0], seedVal & ((a == 8) ? FLAG_W1C_MASK : FULL_MASK));
      rd(a[5:0]);
    end
    for (int i = 0; i < 300; i++)
    begin
      seedVal = lfsr(seedVal);
      evt(seedVal[3:0] & {4{i[2]}});
      if (i[1:0] == 2'b11)
        wr(FLAG_ADDR, lfsr(seedVal) & FLAG_W1C_MASK);
      else
        op(iosb_op_t'(seedVal[1:0]), i[0] ? FLAG_ADDR : seedVal[7:2], 3'(lfsr(seedVal)));
      rd(i[0] ? FLAG_ADDR : seedVal[7:2]);
    end
    // let the last read's compare run before the final sweep
    repeat (2) @(negedge ref_clk);
    for (int a = 0; a < IO_DEPTH; a++)
      check(regView[a], expMem[a]);
    end_of_test();
  end
endmodule : io_space_bit_access_tb_top
`default_nettype wire
